// file: hw/tac_pkg.sv
/*
 * Constants, field layout and types of the translation auxiliary control
 * register bank.
 * Assumes one core clock and a plain register port of word registers.
 */
// Function
// - Nonsecure bit 8, reset 0, gates TLB fill for no-match bypass traffic.
// - Nonsecure bit 4, reset 1, enables intermediate-to-physical cache.
// - Stage-2-only build: bit 4 is reserved, reads zero, no effect.
// - Bit 3, reset 1, enables second-stage level 2 walk cache.
// - Bit 2, reset 1, enables first-stage level 2 walk cache.
// - Secure bit 27 converts non write-back attributes to non-cacheable system.
// - Secure bit 26, reset 1, locks all context registers; clear frees secure.
// - Nonsecure bit 26, reset 1, locks nonsecure context registers.
package tac_pkg;

    // ------------------------------------------------------------
    // Register port and map
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  NS_AUX_OFFSET = 8'h00;
    localparam logic [7:0]  S_AUX_OFFSET  = 8'h04;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int NOMATCH_FILL_BIT = 8;
    localparam int IPA_CACHE_BIT    = 4;
    localparam int S2_WALK_BIT      = 3;
    localparam int S1_WALK_BIT      = 2;
    localparam int NS_LOCK_BIT      = 26;
    localparam int NORMALIZE_BIT    = 27;
    localparam int S_LOCK_BIT       = 26;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic NOMATCH_FILL_RST = 1'h0;
    localparam logic IPA_CACHE_RST    = 1'h1;
    localparam logic S2_WALK_RST      = 1'h1;
    localparam logic S1_WALK_RST      = 1'h1;
    localparam logic NS_LOCK_RST      = 1'h1;
    localparam logic NORMALIZE_RST    = 1'h0;
    localparam logic S_LOCK_RST       = 1'h1;

    // ------------------------------------------------------------
    // Contexts and memory attributes
    // ------------------------------------------------------------
    localparam int          CTX_NUM      = 8;
    localparam logic [1:0]  MEM_DEVICE   = 2'h0;
    localparam logic [1:0]  MEM_NC       = 2'h1;
    localparam logic [1:0]  MEM_WT       = 2'h2;
    localparam logic [1:0]  MEM_WB       = 2'h3;
    localparam logic [1:0]  SHARE_SYSTEM = 2'h3;

    typedef struct packed {
        logic [1:0] inner;
        logic [1:0] outer;
        logic [1:0] share;
    } tac_attr_type;

endpackage

// file: hw/tac_lock_if.sv
/*
 * Carrier between the register bank and the context write-lock gate.
 * Assumes both ends sit in the same core clock domain.
 */
`timescale 1ns/1ps
interface tac_lock_if;
    import tac_pkg::*;

    logic               sec_lock;
    logic               ns_lock;
    logic [CTX_NUM-1:0] ctx_secure;
    logic [CTX_NUM-1:0] ctx_wr;
    logic [CTX_NUM-1:0] ctx_wr_en;

    modport ctrl (
        output sec_lock,
        output ns_lock,
        output ctx_secure,
        output ctx_wr,
        input  ctx_wr_en
    );

    modport gate (
        input  sec_lock,
        input  ns_lock,
        input  ctx_secure,
        input  ctx_wr,
        output ctx_wr_en
    );
endinterface

// file: hw/tac_ctx_lock.sv
/*
 * Per-context write gate for the context auxiliary control registers.
 * Assumes the lock bits come straight from the register bank.
 */
`timescale 1ns/1ps
module tac_ctx_lock (
    tac_lock_if.gate lk
);
    import tac_pkg::*;

    // ------------------------------------------------------------
    // One gate per context
    // ------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < CTX_NUM; n++) begin : g_ctx
            logic locked;
            // Secure lock overrides all; nonsecure also obeys its own
            assign locked = lk.ctx_secure[n] ? lk.sec_lock
                          : (lk.sec_lock | lk.ns_lock);
            assign lk.ctx_wr_en[n] = lk.ctx_wr[n] & ~locked;
        end
    endgenerate
endmodule

// file: hw/tac_aux_ctrl_top.sv
/*
 * Auxiliary control register bank of the translation unit: nonsecure
 * and secure auxiliary registers, cache and fill gates, attribute
 * normalisation and the context register write lock.
 * Assumes a single 40 MHz core clock, a synchronous active-low reset
 * and a register master that never issues read and write together.
 */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module tac_aux_ctrl_top #(
    parameter bit STAGE2_ONLY = 1'b0
) (
    input  wire logic                        I_CORE_CLK,
    input  wire logic                        I_RST_B,
    input  wire logic [tac_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic [tac_pkg::DATA_W-1:0]  I_WDATA,
    input  wire logic                        I_WR,
    input  wire logic                        I_RD,
    input  wire logic                        I_SECURE,
    output logic      [tac_pkg::DATA_W-1:0]  O_RDATA,
    input  wire logic                        I_NOMATCH_FILL_REQ,
    output logic                             O_NOMATCH_FILL_EN,
    input  wire logic                        I_IPA_STORE_REQ,
    output logic                             O_IPA_STORE_EN,
    input  wire logic                        I_S2_WALK_STORE_REQ,
    output logic                             O_S2_WALK_STORE_EN,
    input  wire logic                        I_S1_WALK_STORE_REQ,
    output logic                             O_S1_WALK_STORE_EN,
    output logic                             O_NOMATCH_BYPASS_TLB_FILL,
    output logic                             O_IPA_CACHE_EN,
    output logic                             O_S2_WALK_CACHE_EN,
    output logic                             O_S1_WALK_CACHE_EN,
    output logic                             O_NORMALIZE_EN,
    input  wire logic                        I_ATTR_VALID,
    input  wire tac_pkg::tac_attr_type       I_ATTR,
    output logic                             O_ATTR_VALID,
    output tac_pkg::tac_attr_type            O_ATTR,
    input  wire logic [tac_pkg::CTX_NUM-1:0] I_CTX_SECURE,
    input  wire logic [tac_pkg::CTX_NUM-1:0] I_CTX_WR,
    output logic      [tac_pkg::CTX_NUM-1:0] O_CTX_WR_EN
);
    import tac_pkg::*;

    // ------------------------------------------------------------
    // Writable field masks
    // ------------------------------------------------------------
    // Stage-2-only builds drop the intermediate cache bit entirely
    localparam logic IPA_IMPL = ~STAGE2_ONLY;

    localparam logic [DATA_W-1:0] NS_WMASK =
        (DATA_W'(1) << NOMATCH_FILL_BIT)
        | (DATA_W'(IPA_IMPL) << IPA_CACHE_BIT)
        | (DATA_W'(1) << S2_WALK_BIT)
        | (DATA_W'(1) << S1_WALK_BIT)
        | (DATA_W'(1) << NS_LOCK_BIT);

    localparam logic [DATA_W-1:0] S_WMASK =
        (DATA_W'(1) << NORMALIZE_BIT)
        | (DATA_W'(1) << S_LOCK_BIT);

    localparam logic [DATA_W-1:0] NS_RST =
        (DATA_W'(NOMATCH_FILL_RST) << NOMATCH_FILL_BIT)
        | (DATA_W'(IPA_CACHE_RST & IPA_IMPL) << IPA_CACHE_BIT)
        | (DATA_W'(S2_WALK_RST) << S2_WALK_BIT)
        | (DATA_W'(S1_WALK_RST) << S1_WALK_BIT)
        | (DATA_W'(NS_LOCK_RST) << NS_LOCK_BIT);

    localparam logic [DATA_W-1:0] S_RST =
        (DATA_W'(NORMALIZE_RST) << NORMALIZE_BIT)
        | (DATA_W'(S_LOCK_RST) << S_LOCK_BIT);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ns_aux_reg;
    logic [DATA_W-1:0] ns_aux_next;
    logic [DATA_W-1:0] s_aux_reg;
    logic [DATA_W-1:0] s_aux_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    logic              hit_ns;
    logic              hit_s;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        hit_ns = 1'b0;
        hit_s  = 1'b0;
        if (I_ADDR == NS_AUX_OFFSET) begin
            hit_ns = 1'b1;
        end else if (I_ADDR == S_AUX_OFFSET) begin
            // Nonsecure masters do not see the secure register
            hit_s = I_SECURE;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb begin
        ns_aux_next = ns_aux_reg;
        s_aux_next  = s_aux_reg;
        if (I_WR && hit_ns) begin
            ns_aux_next = I_WDATA & NS_WMASK;
        end
        if (I_WR && hit_s) begin
            s_aux_next = I_WDATA & S_WMASK;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            ns_aux_reg <= NS_RST;
            s_aux_reg  <= S_RST;
        end else begin
            ns_aux_reg <= ns_aux_next;
            s_aux_reg  <= s_aux_next;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Read data stand only in the cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (I_RD && hit_ns) begin
            rdata_next = ns_aux_reg;
        end else if (I_RD && hit_s) begin
            rdata_next = s_aux_reg;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign O_RDATA = rdata_reg;

    // ------------------------------------------------------------
    // Cache and fill enables
    // ------------------------------------------------------------
    assign O_NOMATCH_BYPASS_TLB_FILL = ns_aux_reg[NOMATCH_FILL_BIT];
    assign O_IPA_CACHE_EN            = ns_aux_reg[IPA_CACHE_BIT]
                                     & IPA_IMPL;
    assign O_S2_WALK_CACHE_EN        = ns_aux_reg[S2_WALK_BIT];
    assign O_S1_WALK_CACHE_EN        = ns_aux_reg[S1_WALK_BIT];
    assign O_NORMALIZE_EN            = s_aux_reg[NORMALIZE_BIT];

    // A disabled cache refuses every store, so nothing is allocated
    assign O_NOMATCH_FILL_EN  = I_NOMATCH_FILL_REQ
                              & O_NOMATCH_BYPASS_TLB_FILL;
    assign O_IPA_STORE_EN     = I_IPA_STORE_REQ
                              & O_IPA_CACHE_EN;
    assign O_S2_WALK_STORE_EN = I_S2_WALK_STORE_REQ
                              & O_S2_WALK_CACHE_EN;
    assign O_S1_WALK_STORE_EN = I_S1_WALK_STORE_REQ
                              & O_S1_WALK_CACHE_EN;

    // ------------------------------------------------------------
    // Attribute normalisation
    // ------------------------------------------------------------
    tac_attr_type attr_reg;
    tac_attr_type attr_next;
    logic         attr_vld_reg;
    logic         attr_vld_next;
    logic         attr_wb;

    // Changing the bit mid-traffic mixes old and new attributes in
    // the TLB; software must invalidate first
    always_comb begin
        attr_wb       = (I_ATTR.inner == MEM_WB)
                      && (I_ATTR.outer == MEM_WB);
        attr_vld_next = I_ATTR_VALID;
        attr_next     = attr_reg;
        if (I_ATTR_VALID) begin
            attr_next = I_ATTR;
            if (O_NORMALIZE_EN && !attr_wb) begin
                attr_next.inner = MEM_NC;
                attr_next.outer = MEM_NC;
                attr_next.share = SHARE_SYSTEM;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            attr_reg     <= '0;
            attr_vld_reg <= 1'b0;
        end else begin
            attr_reg     <= attr_next;
            attr_vld_reg <= attr_vld_next;
        end
    end

    assign O_ATTR       = attr_reg;
    assign O_ATTR_VALID = attr_vld_reg;

    // ------------------------------------------------------------
    // Context register write lock
    // ------------------------------------------------------------
    tac_lock_if lock_bus ();

    assign lock_bus.sec_lock   = s_aux_reg[S_LOCK_BIT];
    assign lock_bus.ns_lock    = ns_aux_reg[NS_LOCK_BIT];
    assign lock_bus.ctx_secure = I_CTX_SECURE;
    assign lock_bus.ctx_wr     = I_CTX_WR;
    assign O_CTX_WR_EN         = lock_bus.ctx_wr_en;

    tac_ctx_lock u_ctx_lock (
        .lk (lock_bus.gate)
    );

endmodule

// file: tb/tac_aux_ctrl_assertions.sv
/*
 * Port checker of the auxiliary control bank, bound to its top module.
 * Assumes one core clock, a synchronous active-low reset.
 */
`timescale 1ns/1ps
module tac_aux_ctrl_assertions
    import tac_pkg::*;
#(
    parameter bit STAGE2_ONLY = 1'b0
) (
    input wire logic                I_CORE_CLK,
    input wire logic                I_RST_B,
    input wire logic [ADDR_W-1:0]   I_ADDR,
    input wire logic [DATA_W-1:0]   I_WDATA,
    input wire logic                I_WR,
    input wire logic                I_RD,
    input wire logic                I_SECURE,
    input wire logic [DATA_W-1:0]   O_RDATA,
    input wire logic                I_NOMATCH_FILL_REQ,
    input wire logic                O_NOMATCH_FILL_EN,
    input wire logic                I_IPA_STORE_REQ,
    input wire logic                O_IPA_STORE_EN,
    input wire logic                I_S2_WALK_STORE_REQ,
    input wire logic                O_S2_WALK_STORE_EN,
    input wire logic                I_S1_WALK_STORE_REQ,
    input wire logic                O_S1_WALK_STORE_EN,
    input wire logic                O_NOMATCH_BYPASS_TLB_FILL,
    input wire logic                O_IPA_CACHE_EN,
    input wire logic                O_S2_WALK_CACHE_EN,
    input wire logic                O_S1_WALK_CACHE_EN,
    input wire logic                O_NORMALIZE_EN,
    input wire logic                I_ATTR_VALID,
    input wire tac_attr_type        I_ATTR,
    input wire logic                O_ATTR_VALID,
    input wire tac_attr_type        O_ATTR,
    input wire logic [CTX_NUM-1:0]  I_CTX_SECURE,
    input wire logic [CTX_NUM-1:0]  I_CTX_WR,
    input wire logic [CTX_NUM-1:0]  O_CTX_WR_EN
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    // ------------------------------------------------------------
    // Helper state: lock bits shadowed from register writes
    // ------------------------------------------------------------
    logic ns_lk_reg, ns_lk_next, s_lk_reg, s_lk_next, w27, cvt;
    assign w27 = I_WDATA[NORMALIZE_BIT];
    assign cvt = O_NORMALIZE_EN
               && !(I_ATTR.inner == MEM_WB && I_ATTR.outer == MEM_WB);
    always_comb begin
        ns_lk_next = ns_lk_reg;
        s_lk_next  = s_lk_reg;
        if (I_WR && I_ADDR == NS_AUX_OFFSET) ns_lk_next = I_WDATA[26];
        if (I_WR && I_ADDR == S_AUX_OFFSET && I_SECURE) s_lk_next = w27 ^
            I_WDATA[27] ^ I_WDATA[26];
    end
    always_ff @(posedge I_CORE_CLK) begin
        ns_lk_reg <= I_RST_B ? ns_lk_next : 1'b1;
        s_lk_reg  <= I_RST_B ? s_lk_next : 1'b1;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ns;
        logic [31:0] d;
        (I_WR && I_ADDR == NS_AUX_OFFSET, d = I_WDATA) |=>
            {O_NOMATCH_BYPASS_TLB_FILL, O_S2_WALK_CACHE_EN,
             O_S1_WALK_CACHE_EN} == {d[8], d[3], d[2]};
    endproperty
    property p_ipa;
        logic [31:0] d;
        (I_WR && I_ADDR == NS_AUX_OFFSET, d = I_WDATA) |=>
            O_IPA_CACHE_EN == (d[4] && !STAGE2_ONLY);
    endproperty
    ns_write_a: assert property (p_ns)
        else $error("nonsecure enable outputs wrong after write");
    ipa_write_a: assert property (p_ipa)
        else $error("cache enable wrong after write");
    fill_gate_a: assert property (O_NOMATCH_FILL_EN ==
        (I_NOMATCH_FILL_REQ && O_NOMATCH_BYPASS_TLB_FILL))
        else $error("no-match fill gate wrong");
    ipa_gate_a: assert property (O_IPA_STORE_EN ==
        (I_IPA_STORE_REQ && O_IPA_CACHE_EN)) else $error("ipa gate wrong");
    walk_gate_a: assert property ({O_S2_WALK_STORE_EN,
        O_S1_WALK_STORE_EN} == {I_S2_WALK_STORE_REQ && O_S2_WALK_CACHE_EN,
        I_S1_WALK_STORE_REQ && O_S1_WALK_CACHE_EN})
        else $error("walk store gate wrong");
    norm_write_a: assert property (I_WR && I_ADDR == S_AUX_OFFSET
        |=> O_NORMALIZE_EN == ($past(I_SECURE) ? $past(w27)
        : $past(O_NORMALIZE_EN))) else $error("normalize bit wrong");
    attr_path_a: assert property (I_ATTR_VALID |=> O_ATTR_VALID
        && O_ATTR == ($past(cvt) ? tac_attr_type'({MEM_NC, MEM_NC,
        SHARE_SYSTEM}) : $past(I_ATTR))) else $error("attribute wrong");
    lock_gate_a: assert property (O_CTX_WR_EN == (I_CTX_WR &
        ~({CTX_NUM{s_lk_reg}} | (~I_CTX_SECURE & {CTX_NUM{ns_lk_reg}}))))
        else $error("context write permit wrong");
    rd_ns_a: assert property (I_RD && I_ADDR == NS_AUX_OFFSET
        |=> (O_RDATA & ~32'h0400011C) == 32'h0)
        else $error("reserved nonsecure bits read nonzero");
    rd_sec_a: assert property (I_RD && I_ADDR == S_AUX_OFFSET
        |=> (O_RDATA & ~($past(I_SECURE) ? 32'h0C000000 : 32'h0)) == 32'h0)
        else $error("reserved secure bits read nonzero");
    rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data outside read cycle");

    cover property (I_WR && I_ADDR == S_AUX_OFFSET && I_SECURE);
    cover property (O_ATTR_VALID && O_NORMALIZE_EN);
    cover property (|O_CTX_WR_EN);
endmodule

bind tac_aux_ctrl_top tac_aux_ctrl_assertions #(
    .STAGE2_ONLY(STAGE2_ONLY)) chk_u (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_SECURE(I_SECURE),
    .O_RDATA(O_RDATA), .I_NOMATCH_FILL_REQ(I_NOMATCH_FILL_REQ),
    .O_NOMATCH_FILL_EN(O_NOMATCH_FILL_EN),
    .I_IPA_STORE_REQ(I_IPA_STORE_REQ), .O_IPA_STORE_EN(O_IPA_STORE_EN),
    .I_S2_WALK_STORE_REQ(I_S2_WALK_STORE_REQ),
    .O_S2_WALK_STORE_EN(O_S2_WALK_STORE_EN),
    .I_S1_WALK_STORE_REQ(I_S1_WALK_STORE_REQ),
    .O_S1_WALK_STORE_EN(O_S1_WALK_STORE_EN),
    .O_NOMATCH_BYPASS_TLB_FILL(O_NOMATCH_BYPASS_TLB_FILL),
    .O_IPA_CACHE_EN(O_IPA_CACHE_EN), .O_S2_WALK_CACHE_EN(O_S2_WALK_CACHE_EN),
    .O_S1_WALK_CACHE_EN(O_S1_WALK_CACHE_EN), .O_NORMALIZE_EN(O_NORMALIZE_EN),
    .I_ATTR_VALID(I_ATTR_VALID), .I_ATTR(I_ATTR),
    .O_ATTR_VALID(O_ATTR_VALID), .O_ATTR(O_ATTR),
    .I_CTX_SECURE(I_CTX_SECURE), .I_CTX_WR(I_CTX_WR),
    .O_CTX_WR_EN(O_CTX_WR_EN));

// file: tb/test_translation_aux_control.sv
/*
 * Self-checking bench of the auxiliary control bank with a register model.
 * Assumes the checker is bound to the top module.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_translation_aux_control;
    import tac_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, sec = 0, av = 0;
    logic [7:0] addr = 0, ctxs = 0, ctxw = 0, ctxen;
    logic [31:0] wdata = 0, rdata, rdata2, ns, sr, d;
    logic [3:0] req = 0, gen;
    logic fill, ipac, s2c, s1c, norm, oav, ipac2, ipa2_en;
    tac_attr_type attr = 0, oattr;
    logic [7:0] tbl [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h08, 8'hFC};
    int failures = 0, cmp_count = 0, cyc = 0;

    always #12.5 clk = ~clk;

    tac_aux_ctrl_top dut_u (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .I_SECURE(sec), .O_RDATA(rdata),
        .I_NOMATCH_FILL_REQ(req[3]), .O_NOMATCH_FILL_EN(gen[3]),
        .I_IPA_STORE_REQ(req[2]), .O_IPA_STORE_EN(gen[2]),
        .I_S2_WALK_STORE_REQ(req[1]), .O_S2_WALK_STORE_EN(gen[1]),
        .I_S1_WALK_STORE_REQ(req[0]), .O_S1_WALK_STORE_EN(gen[0]),
        .O_NOMATCH_BYPASS_TLB_FILL(fill), .O_IPA_CACHE_EN(ipac),
        .O_S2_WALK_CACHE_EN(s2c), .O_S1_WALK_CACHE_EN(s1c),
        .O_NORMALIZE_EN(norm), .I_ATTR_VALID(av), .I_ATTR(attr),
        .O_ATTR_VALID(oav), .O_ATTR(oattr), .I_CTX_SECURE(ctxs),
        .I_CTX_WR(ctxw), .O_CTX_WR_EN(ctxen));

    // Stage-2-only build shares every input; its cache bit must stay dead
    tac_aux_ctrl_top #(.STAGE2_ONLY(1'b1)) dut_s2_u (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .I_SECURE(sec), .O_RDATA(rdata2),
        .I_NOMATCH_FILL_REQ(req[3]), .O_NOMATCH_FILL_EN(),
        .I_IPA_STORE_REQ(req[2]), .O_IPA_STORE_EN(ipa2_en),
        .I_S2_WALK_STORE_REQ(req[1]), .O_S2_WALK_STORE_EN(),
        .I_S1_WALK_STORE_REQ(req[0]), .O_S1_WALK_STORE_EN(),
        .O_NOMATCH_BYPASS_TLB_FILL(), .O_IPA_CACHE_EN(ipac2),
        .O_S2_WALK_CACHE_EN(), .O_S1_WALK_CACHE_EN(),
        .O_NORMALIZE_EN(), .I_ATTR_VALID(av), .I_ATTR(attr),
        .O_ATTR_VALID(), .O_ATTR(), .I_CTX_SECURE(ctxs),
        .I_CTX_WR(ctxw), .O_CTX_WR_EN());

    // ------------------------------------------------------------
    // Register port tasks with the bench model
    // ------------------------------------------------------------
    task reg_wr(input logic [7:0] a, input logic [31:0] v, input logic s);
        @(posedge clk);
        addr <= a; wdata <= v; sec <= s; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == NS_AUX_OFFSET) ns = v & 32'h0400011C;
        else if (a == S_AUX_OFFSET && s) sr = v & 32'h0C000000;
    endtask

    task reg_rd(input logic [7:0] a, input logic s);
        logic [31:0] e;
        e = (a == NS_AUX_OFFSET) ? ns : (a == S_AUX_OFFSET && s) ? sr : 0;
        @(posedge clk);
        addr <= a; sec <= s; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
        `CHK(rdata2, e & ~(32'h1 << IPA_CACHE_BIT))
        `CHK(oav, 1'b0)
    endtask

    // Attribute traffic runs only between writes, so bit 27 never
    // changes under a live transaction
    task stim();
        logic [7:0] lk;
        tac_attr_type ea;
        @(posedge clk);
        req <= 4'($urandom); ctxs <= 8'($urandom); ctxw <= 8'($urandom);
        attr <= tac_attr_type'(6'($urandom)); av <= 1'b1;
        @(posedge clk);
        av <= 1'b0;
        #1 `CHK(gen, req & {ns[8], ns[4], ns[3], ns[2]})
        `CHK({fill, ipac, s2c, s1c, norm}, {ns[8], ns[4:2], sr[27]})
        `CHK({ipac2, ipa2_en}, 2'h0)
        lk = {8{sr[26]}} | (~ctxs & {8{ns[26]}});
        `CHK(ctxen, ctxw & ~lk)
        ea = (sr[27] && !(attr.inner == MEM_WB && attr.outer == MEM_WB)) ?
            tac_attr_type'({MEM_NC, MEM_NC, SHARE_SYSTEM}) : attr;
        `CHK({oav, oattr}, {1'b1, ea})
    endtask

    task results();
        $display("Comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A hang past the expected few hundred cycles counts as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end

    initial begin
        void'($urandom(69));
        ns = 32'h0400001C;
        sr = 32'h04000000;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        reg_rd(8'h00, 1'b0);
        reg_rd(8'h04, 1'b1);
        reg_rd(8'h04, 1'b0);
        stim();
        for (int i = 0; i < 40; i++) begin
            d = $urandom;
            reg_wr(tbl[$urandom % 6], d, 1'($urandom));
            stim();
            reg_rd(addr, 1'($urandom));
        end
        results();
    end
endmodule
